// ===== src/irq_bank_pkg.sv
// Package with register map, field positions and carrier types of the peripheral interrupt bank.
package irq_bank_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SECOND = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_REQUEST_FIRST = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CORE_CONTROL = 4'h8;
  localparam logic [7:0] ENABLE_SECOND_RESET = 8'h00;
  localparam logic [7:0] REQUEST_FIRST_RESET = 8'h00;
  localparam logic [1:0] CORE_CONTROL_RESET = 2'h0;
  // Enable bank field positions.
  localparam int unsigned EN_OSC_FAIL = 7;
  localparam int unsigned EN_CMP_TWO = 6;
  localparam int unsigned EN_CMP_ONE = 5;
  localparam int unsigned EN_NVM_DONE = 4;
  localparam int unsigned EN_BUS_COLL = 3;
  localparam logic [7:0] EN_IMPL_MASK_LARGE = 8'hF8;
  localparam logic [7:0] EN_IMPL_MASK_SMALL = 8'hB8;
  // Request bank field positions.
  localparam int unsigned RQ_UART_RX = 5;
  localparam int unsigned RQ_UART_TX = 4;
  localparam int unsigned RQ_TIMER_GATE = 7;
  localparam int unsigned RQ_CONVERTER = 6;
  localparam int unsigned RQ_SYNC_SERIAL = 3;
  localparam int unsigned RQ_CAPTURE = 2;
  localparam int unsigned RQ_PERIOD = 1;
  localparam int unsigned RQ_OVERFLOW = 0;
  localparam logic [7:0] RQ_SW_WRITE_MASK = 8'hCF;
  localparam logic [7:0] RQ_MIRROR_MASK = 8'h30;
  // Core control field positions.
  localparam int unsigned CC_GLOBAL = 1;
  localparam int unsigned CC_PERIPH = 0;

  typedef struct packed {
    logic [7:0] enable_second;
    logic [7:0] request_first;
    logic [1:0] core_ctrl;
    logic ack;
    logic [DATA_W-1:0] rdata;
  } state_type;

  // Events of the second bank whose enables live here; their flags live elsewhere.
  typedef struct packed {
    logic osc_fail;
    logic cmp_two;
    logic cmp_one;
    logic nvm_done;
    logic bus_coll;
  } pend_second_type;
endpackage

// ===== src/irq_bank.sv
// Peripheral interrupt enable and request bank with a classic Wishbone slave.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module irq_bank
  import irq_bank_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Wishbone slave.
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [ADDR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [DATA_W-1:0] DAT_I,
  output logic [DATA_W-1:0] DAT_O,
  output logic ACK_O,
  // Peripheral events and levels.
  input wire logic [7:0] REQ_EVENT_I,
  input wire logic UART_RX_PEND_I,
  input wire logic UART_TX_PEND_I,
  input wire pend_second_type PEND_SECOND_I,
  // Enables and interrupt outputs.
  output logic [7:0] ENABLE_SECOND_O,
  output logic [7:0] REQUEST_FIRST_O,
  output logic PERIPH_REQ_O,
  output logic IRQ_O
);

  localparam logic [7:0] EN_MASK = LARGE_VARIANT ? EN_IMPL_MASK_LARGE : EN_IMPL_MASK_SMALL;

  state_type state_r;
  state_type state_nxt;
  logic access;
  logic [7:0] sw_clear;
  logic [7:0] sw_set;
  logic [7:0] gated_second;
  logic [7:0] gated_first;
  logic [7:0] pend_second_vec;
  logic wr_en_second;
  logic wr_req_first;
  logic wr_core;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  assign access = CYC_I && STB_I && !state_r.ack;

  // Write strobes per register, used by the checks below.
  assign wr_en_second = access && WE_I && SEL_I[0] && hit(ADR_I, OFS_ENABLE_SECOND);
  assign wr_req_first = access && WE_I && SEL_I[0] && hit(ADR_I, OFS_REQUEST_FIRST);
  assign wr_core = access && WE_I && SEL_I[0] && hit(ADR_I, OFS_CORE_CONTROL);

  always_comb
  begin
    pend_second_vec = 8'h00;
    pend_second_vec[EN_OSC_FAIL] = PEND_SECOND_I.osc_fail;
    pend_second_vec[EN_CMP_TWO] = PEND_SECOND_I.cmp_two;
    pend_second_vec[EN_CMP_ONE] = PEND_SECOND_I.cmp_one;
    pend_second_vec[EN_NVM_DONE] = PEND_SECOND_I.nvm_done;
    pend_second_vec[EN_BUS_COLL] = PEND_SECOND_I.bus_coll;
  end

  // Each second-bank source passes only with its own enable bit.
  assign gated_second = pend_second_vec & state_r.enable_second;
  // Enable bank has no first-bank enables here, so the request flags feed the combined output ungated.
  assign gated_first = state_r.request_first;
  assign PERIPH_REQ_O = |gated_second || |gated_first;
  assign IRQ_O = PERIPH_REQ_O && state_r.core_ctrl[CC_PERIPH] && state_r.core_ctrl[CC_GLOBAL];

  always_comb
  begin
    state_nxt = state_r;
    sw_clear = 8'h00;
    sw_set = 8'h00;
    state_nxt.ack = access;
    if (access && WE_I && SEL_I[0])
    begin
      if (hit(ADR_I, OFS_ENABLE_SECOND))
      begin
        state_nxt.enable_second = DAT_I[7:0] & EN_MASK;
      end
      if (hit(ADR_I, OFS_REQUEST_FIRST))
      begin
        sw_clear = ~DAT_I[7:0] & RQ_SW_WRITE_MASK;
        sw_set = DAT_I[7:0] & RQ_SW_WRITE_MASK;
      end
      if (hit(ADR_I, OFS_CORE_CONTROL))
      begin
        state_nxt.core_ctrl = DAT_I[1:0];
      end
    end
    // A hardware event in the same cycle as a clear wins, so no request is lost.
    state_nxt.request_first = ((state_r.request_first & ~sw_clear) | sw_set | REQ_EVENT_I) & RQ_SW_WRITE_MASK;
    state_nxt.request_first[RQ_UART_RX] = UART_RX_PEND_I;
    state_nxt.request_first[RQ_UART_TX] = UART_TX_PEND_I;
    state_nxt.rdata = '0;
    if (access && !WE_I)
    begin
      if (hit(ADR_I, OFS_ENABLE_SECOND))
      begin
        state_nxt.rdata[7:0] = state_r.enable_second;
      end
      else if (hit(ADR_I, OFS_REQUEST_FIRST))
      begin
        state_nxt.rdata[7:0] = state_r.request_first;
      end
      else if (hit(ADR_I, OFS_CORE_CONTROL))
      begin
        state_nxt.rdata[1:0] = state_r.core_ctrl;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      state_r.enable_second <= ENABLE_SECOND_RESET;
      state_r.request_first <= REQUEST_FIRST_RESET;
      state_r.core_ctrl <= CORE_CONTROL_RESET;
      state_r.ack <= 1'b0;
      state_r.rdata <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign ACK_O = state_r.ack;
  assign DAT_O = state_r.rdata;
  assign ENABLE_SECOND_O = state_r.enable_second;
  assign REQUEST_FIRST_O = state_r.request_first;

  // Stale flags are not hidden when a source is enabled, so software has to clear them first.

  // Reset is checked while it is held, so these checks carry no disable clause.
  AST_RESET_CLEAR: assert property (@(posedge CLK_I)
    !RST_B_I |-> (state_r.enable_second == ENABLE_SECOND_RESET && state_r.request_first == REQUEST_FIRST_RESET))
    else $error("Registers not cleared in reset");

  AST_RESET_CORE: assert property (@(posedge CLK_I)
    !RST_B_I |-> (state_r.core_ctrl == CORE_CONTROL_RESET && !IRQ_O))
    else $error("Core control not cleared in reset");

  AST_EN_LOW_ZERO: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    state_r.enable_second[2:0] == 3'h0)
    else $error("Unimplemented enable bits set");

  AST_CMP_TWO_SMALL: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !LARGE_VARIANT |-> !state_r.enable_second[EN_CMP_TWO])
    else $error("Second comparator enable present on small variant");

  AST_CMP_TWO_LARGE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (LARGE_VARIANT && wr_en_second && DAT_I[EN_CMP_TWO]) |=> state_r.enable_second[EN_CMP_TWO])
    else $error("Second comparator enable not writable on large variant");

  AST_EN_WRITE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    wr_en_second |=> state_r.enable_second == ($past(DAT_I[7:0]) & EN_MASK))
    else $error("Enable write did not land");

  AST_EN_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !wr_en_second |=> $stable(state_r.enable_second))
    else $error("Enable register changed without a write");

  AST_OSC_GATE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PEND_SECOND_I.osc_fail && state_r.enable_second[EN_OSC_FAIL]) |-> PERIPH_REQ_O)
    else $error("Oscillator fail not forwarded");

  AST_OSC_BLOCK: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PEND_SECOND_I == 5'h10 && !state_r.enable_second[EN_OSC_FAIL] && state_r.request_first == 8'h00)
    |-> !PERIPH_REQ_O)
    else $error("Oscillator fail passed while disabled");

  AST_CMP_TWO_GATE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PEND_SECOND_I.cmp_two && state_r.enable_second[EN_CMP_TWO]) |-> PERIPH_REQ_O)
    else $error("Second comparator not forwarded");

  AST_CMP_TWO_BLOCK: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PEND_SECOND_I == 5'h08 && !state_r.enable_second[EN_CMP_TWO] && state_r.request_first == 8'h00)
    |-> !PERIPH_REQ_O)
    else $error("Second comparator passed while disabled");

  AST_CMP_ONE_GATE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PEND_SECOND_I.cmp_one && state_r.enable_second[EN_CMP_ONE]) |-> PERIPH_REQ_O)
    else $error("First comparator not forwarded");

  AST_CMP_ONE_BLOCK: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PEND_SECOND_I == 5'h04 && !state_r.enable_second[EN_CMP_ONE] && state_r.request_first == 8'h00)
    |-> !PERIPH_REQ_O)
    else $error("First comparator passed while disabled");

  AST_NVM_GATE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PEND_SECOND_I.nvm_done && state_r.enable_second[EN_NVM_DONE]) |-> PERIPH_REQ_O)
    else $error("Write completion not forwarded");

  AST_NVM_BLOCK: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PEND_SECOND_I == 5'h02 && !state_r.enable_second[EN_NVM_DONE] && state_r.request_first == 8'h00)
    |-> !PERIPH_REQ_O)
    else $error("Write completion passed while disabled");

  AST_BUS_GATE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PEND_SECOND_I.bus_coll && state_r.enable_second[EN_BUS_COLL]) |-> PERIPH_REQ_O)
    else $error("Bus collision not forwarded");

  AST_BUS_BLOCK: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PEND_SECOND_I == 5'h01 && !state_r.enable_second[EN_BUS_COLL] && state_r.request_first == 8'h00)
    |-> !PERIPH_REQ_O)
    else $error("Bus collision passed while disabled");

  AST_ALL_BLOCKED: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r.enable_second == 8'h00 && state_r.request_first == 8'h00) |-> !PERIPH_REQ_O)
    else $error("Combined request without any source");

  AST_FLAG_PASS: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r.request_first != 8'h00) |-> PERIPH_REQ_O)
    else $error("Pending flag not in combined request");

  AST_SET_TIMER_GATE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    REQ_EVENT_I[RQ_TIMER_GATE] |=> state_r.request_first[RQ_TIMER_GATE])
    else $error("Timer gate event did not set flag");

  AST_SET_CONVERTER: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    REQ_EVENT_I[RQ_CONVERTER] |=> state_r.request_first[RQ_CONVERTER])
    else $error("Converter event did not set flag");

  AST_SET_SYNC_SERIAL: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    REQ_EVENT_I[RQ_SYNC_SERIAL] |=> state_r.request_first[RQ_SYNC_SERIAL])
    else $error("Sync serial event did not set flag");

  AST_SET_CAPTURE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    REQ_EVENT_I[RQ_CAPTURE] |=> state_r.request_first[RQ_CAPTURE])
    else $error("Capture compare event did not set flag");

  AST_SET_PERIOD: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    REQ_EVENT_I[RQ_PERIOD] |=> state_r.request_first[RQ_PERIOD])
    else $error("Period match event did not set flag");

  AST_EVENT_SETS: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    REQ_EVENT_I[RQ_OVERFLOW] |=> state_r.request_first[RQ_OVERFLOW])
    else $error("Overflow event did not set flag");

  AST_CLR_TIMER_GATE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (wr_req_first && !DAT_I[RQ_TIMER_GATE] && !REQ_EVENT_I[RQ_TIMER_GATE]) |=> !state_r.request_first[RQ_TIMER_GATE])
    else $error("Software clear of timer gate flag failed");

  AST_CLR_CONVERTER: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (wr_req_first && !DAT_I[RQ_CONVERTER] && !REQ_EVENT_I[RQ_CONVERTER]) |=> !state_r.request_first[RQ_CONVERTER])
    else $error("Software clear of converter flag failed");

  AST_CLR_SYNC_SERIAL: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (wr_req_first && !DAT_I[RQ_SYNC_SERIAL] && !REQ_EVENT_I[RQ_SYNC_SERIAL]) |=> !state_r.request_first[RQ_SYNC_SERIAL])
    else $error("Software clear of sync serial flag failed");

  AST_CLR_CAPTURE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (wr_req_first && !DAT_I[RQ_CAPTURE] && !REQ_EVENT_I[RQ_CAPTURE]) |=> !state_r.request_first[RQ_CAPTURE])
    else $error("Software clear of capture compare flag failed");

  AST_CLR_PERIOD: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (wr_req_first && !DAT_I[RQ_PERIOD] && !REQ_EVENT_I[RQ_PERIOD]) |=> !state_r.request_first[RQ_PERIOD])
    else $error("Software clear of period match flag failed");

  AST_SW_CLEAR: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (wr_req_first && !DAT_I[RQ_OVERFLOW] && !REQ_EVENT_I[RQ_OVERFLOW]) |=> !state_r.request_first[RQ_OVERFLOW])
    else $error("Software clear of flag failed");

  AST_RQ_WRITE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    wr_req_first |=> (state_r.request_first & RQ_SW_WRITE_MASK)
    == (($past(DAT_I[7:0]) | $past(REQ_EVENT_I)) & RQ_SW_WRITE_MASK))
    else $error("Request write did not land");

  AST_RQ_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (!wr_req_first && REQ_EVENT_I == 8'h00) |=> (state_r.request_first & RQ_SW_WRITE_MASK)
    == ($past(state_r.request_first) & RQ_SW_WRITE_MASK))
    else $error("Request flag changed without cause");

  AST_EVENT_WINS: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (wr_req_first && REQ_EVENT_I[RQ_OVERFLOW]) |=> state_r.request_first[RQ_OVERFLOW])
    else $error("Clear beat a same-cycle event");

  AST_RX_MIRROR: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    1'b1 |=> state_r.request_first[RQ_UART_RX] == $past(UART_RX_PEND_I))
    else $error("Receive flag does not mirror source");

  AST_TX_MIRROR: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    1'b1 |=> state_r.request_first[RQ_UART_TX] == $past(UART_TX_PEND_I))
    else $error("Transmit flag does not mirror source");

  AST_RD_REQUEST: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (access && !WE_I && hit(ADR_I, OFS_REQUEST_FIRST)) |=> DAT_O[7:0] == $past(state_r.request_first))
    else $error("Request read returned wrong value");

  AST_RD_EN_LOW: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (access && !WE_I && hit(ADR_I, OFS_ENABLE_SECOND)) |=> DAT_O[2:0] == 3'h0)
    else $error("Unimplemented enable bits read nonzero");

  AST_IRQ_PERIPH: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !state_r.core_ctrl[CC_PERIPH] |-> !IRQ_O)
    else $error("Interrupt without peripheral group enable");

  AST_IRQ_GLOBAL: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !state_r.core_ctrl[CC_GLOBAL] |-> !IRQ_O)
    else $error("Interrupt without global enable");

  AST_GLOBAL_PASS: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (PERIPH_REQ_O && state_r.core_ctrl[CC_PERIPH] && state_r.core_ctrl[CC_GLOBAL]) |-> IRQ_O)
    else $error("Active request blocked with enables set");

  AST_IRQ_GATED: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !PERIPH_REQ_O |-> !IRQ_O)
    else $error("Interrupt without a combined request");

  AST_CORE_WRITE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    wr_core |=> state_r.core_ctrl == $past(DAT_I[1:0]))
    else $error("Core control write did not land");

  AST_ACK_NEXT: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    access |=> ACK_O)
    else $error("Request not acknowledged in the next cycle");

  AST_ACK_ONE: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    ACK_O |=> !ACK_O)
    else $error("Acknowledge held two cycles");

  COV_IRQ: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(IRQ_O));

  COV_WRITE_EN: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
    access && WE_I && ADR_I == OFS_ENABLE_SECOND);

  COV_SET_CLEAR: cover property (@(posedge CLK_I) disable iff (!RST_B_I) |(sw_clear & REQ_EVENT_I));

  COV_RX_RISE: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(state_r.request_first[RQ_UART_RX]));

endmodule
`default_nettype wire

// ===== sim/periph_model.sv
// Peripheral model that raises interrupt events and pending levels toward the bank.
`timescale 1ns/1ns
`default_nettype none
module periph_model
  import irq_bank_pkg::*;
(
  // Clock, reset and bench commands.
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] fire_i,
  input wire logic [6:0] lvl_i,
  // Toward the bank.
  output logic [7:0] event_o,
  output logic [1:0] uart_o,
  output pend_second_type pend_o
);
  // Events are one-cycle pulses; levels stay until the peripheral withdraws them.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      event_o <= 8'h00;
      uart_o <= 2'h0;
      pend_o <= '0;
    end
    else
    begin
      event_o <= fire_i;
      uart_o <= lvl_i[6:5];
      pend_o <= pend_second_type'(lvl_i[4:0]);
    end
  end
endmodule
`default_nettype wire

// ===== sim/irq_bank_tb.sv
// Self-checking bench for the peripheral interrupt bank.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("Error %s expected %h seen %h", n, e, g); end end
module irq_bank_tb;
  import irq_bank_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] dat = '0;
  logic [7:0] fire = 8'h00;
  logic [6:0] lvl = 7'h00;
  logic [DATA_W-1:0] dat_o;
  logic ack, preq, irq;
  logic [7:0] en_o, rq_o, ev, q, en_s;
  logic [23:0] qhi;
  logic [3:0] sel = 4'hF;
  logic [1:0] uart;
  pend_second_type pend;
  int errors = 0;
  int comparisons = 0;
  always #5 CLK_I = ~CLK_I;
  periph_model periph_model_inst (.clk_i(CLK_I), .rst_b_i(RST_B_I), .fire_i(fire), .lvl_i(lvl),
    .event_o(ev), .uart_o(uart), .pend_o(pend));
  irq_bank irq_bank_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CYC_I(cyc), .STB_I(cyc), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .REQ_EVENT_I(ev),
    .UART_RX_PEND_I(uart[1]), .UART_TX_PEND_I(uart[0]), .PEND_SECOND_I(pend),
    .ENABLE_SECOND_O(en_o), .REQUEST_FIRST_O(rq_o), .PERIPH_REQ_O(preq), .IRQ_O(irq));
  // The small variant shadows every bus access so its missing enable bit can be seen.
  irq_bank #(.LARGE_VARIANT(1'b0)) irq_bank_small_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CYC_I(cyc),
    .STB_I(cyc), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(), .ACK_O(), .REQ_EVENT_I(ev),
    .UART_RX_PEND_I(uart[1]), .UART_TX_PEND_I(uart[0]), .PEND_SECOND_I(pend),
    .ENABLE_SECOND_O(en_s), .REQUEST_FIRST_O(), .PERIPH_REQ_O(), .IRQ_O());
  task wrap_up();
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Ack and read data are taken at the rising edge that samples ack high, then the request drops.
  task wb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge CLK_I);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge CLK_I);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      errors++;
      wrap_up();
    end
    q = dat_o[7:0];
    qhi = dat_o[DATA_W-1:8];
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task rd(input string n, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(n, e, q)
    `CHK("upper", 24'h000000, qhi)
  endtask
  task put(input logic [7:0] f, input logic [6:0] l);
    @(posedge CLK_I);
    fire <= f;
    lvl <= l;
    @(posedge CLK_I);
    fire <= 8'h00;
    repeat (3) @(posedge CLK_I);
    @(negedge CLK_I);
  endtask
  task t_reset();
    rd("enable", OFS_ENABLE_SECOND, 8'h00);
    rd("request", OFS_REQUEST_FIRST, 8'h00);
    rd("core", OFS_CORE_CONTROL, 8'h00);
    `CHK("irq", 1'b0, irq)
  endtask
  task t_enable();
    wb(1'b1, OFS_ENABLE_SECOND, 8'hFF);
    rd("enable", OFS_ENABLE_SECOND, 8'hF8);
    `CHK("enable_o", 8'hF8, en_o)
    `CHK("enable_small", 8'hB8, en_s)
    wb(1'b1, OFS_ENABLE_SECOND, 8'h07);
    rd("enable", OFS_ENABLE_SECOND, 8'h00);
    wb(1'b1, 4'hC, 8'hFF);
    rd("unmapped", 4'hC, 8'h00);
    sel <= 4'hE;
    wb(1'b1, OFS_ENABLE_SECOND, 8'hFF);
    sel <= 4'hF;
    rd("lane", OFS_ENABLE_SECOND, 8'h00);
  endtask
  task t_flags();
    put(8'hFF, 7'h00);
    rd("request", OFS_REQUEST_FIRST, 8'hCF);
    `CHK("preq", 1'b1, preq)
    `CHK("irq", 1'b0, irq)
    wb(1'b1, OFS_CORE_CONTROL, 8'h01);
    @(negedge CLK_I);
    `CHK("irq", 1'b0, irq)
    wb(1'b1, OFS_CORE_CONTROL, 8'h02);
    @(negedge CLK_I);
    `CHK("irq", 1'b0, irq)
    wb(1'b1, OFS_CORE_CONTROL, 8'h03);
    @(negedge CLK_I);
    `CHK("irq", 1'b1, irq)
    wb(1'b1, OFS_REQUEST_FIRST, 8'hFF);
    rd("request", OFS_REQUEST_FIRST, 8'hCF);
    wb(1'b1, OFS_REQUEST_FIRST, 8'h00);
    rd("request", OFS_REQUEST_FIRST, 8'h00);
    `CHK("preq", 1'b0, preq)
  endtask
  task t_mirror();
    put(8'h00, 7'h40);
    rd("request", OFS_REQUEST_FIRST, 8'h20);
    `CHK("request_o", 8'h20, rq_o)
    put(8'h00, 7'h20);
    rd("request", OFS_REQUEST_FIRST, 8'h10);
    put(8'h00, 7'h00);
    rd("request", OFS_REQUEST_FIRST, 8'h00);
  endtask
  task t_second();
    rd("request", OFS_REQUEST_FIRST, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      put(8'h00, 7'h01 << i);
      `CHK("preq", 1'b0, preq)
      wb(1'b1, OFS_ENABLE_SECOND, 8'h08 << i);
      @(negedge CLK_I);
      `CHK("irq", 1'b1, irq)
      wb(1'b1, OFS_ENABLE_SECOND, 8'h00);
    end
  endtask
  task t_midreset();
    wb(1'b1, OFS_ENABLE_SECOND, 8'hFF);
    @(posedge CLK_I);
    RST_B_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    rd("enable", OFS_ENABLE_SECOND, 8'h00);
    rd("core", OFS_CORE_CONTROL, 8'h00);
  endtask
  initial
  begin
    repeat (2) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    t_reset();
    t_enable();
    t_flags();
    t_mirror();
    t_second();
    t_midreset();
    wrap_up();
  end
endmodule
`default_nettype wire
